// File: hdl/cep_base_timer.sv
// Eight-bit PWM base timer with period match and output postscaler
`timescale 1ns/1ns
module cep_base_timer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Pacing and settings
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] period,
   input  wire logic [3:0]       post_sel,
   // Outputs
   output logic [WIDTH-1:0]      count_ff,
   output logic                  period_end,
   output logic                  post_event_ff
);

   logic [3:0] post_cnt_ff;

   assign period_end = tick && (count_ff == period);

   // Match with the period register wraps the count on the next increment
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_ff <= '0;
      end else if (period_end) begin
         count_ff <= '0;
      end else if (tick) begin
         count_ff <= count_ff + WIDTH'(1);
      end
   end

   // Postscaler only paces the timer event, never the period itself
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         post_cnt_ff   <= 4'h0;
         post_event_ff <= 1'b0;
      end else begin
         post_event_ff <= 1'b0;
         if (period_end) begin
            if (post_cnt_ff >= post_sel) begin
               post_cnt_ff   <= 4'h0;
               post_event_ff <= 1'b1;
            end else begin
               post_cnt_ff <= post_cnt_ff + 4'h1;
            end
         end
      end
   end

   a_period_wrap: assert property (@(posedge clk) disable iff (reset)
      period_end |=> count_ff == '0)
      else $error("timer did not clear after period match");

endmodule

// File: hdl/cep_channel.sv
// Capture/compare channel: special event trigger and single-output PWM with Wishbone registers
//
// Contract
// - Special event trigger resets the first or third timer, whichever is selected.
// - Enhanced channel trigger also starts a conversion, only when converter enabled.
// - Trigger-caused timer reset never sets the first or third timer flag.
// - PWM mode drives the channel pin with up to ten-bit duty resolution.
// - Writing zero control forces the PWM latch low; port data latch untouched.
// - Timer equal to period clears the timer on the next increment.
// - Same increment sets the pin high unless duty is zero.
// - Same increment copies low duty byte and two bits into the buffer.
// - Timer postscaler affects only the timer event rate, not PWM period.
// - Duty is low byte as upper eight bits, control bits 5:4 lower two.
// - High time equals duty times oscillator period times prescale.
// - Duty writes allowed anytime; applied only at the end of a period.
// - In PWM mode the high duty byte is read-only; writes ignored.
// - Duty double-buffered in high byte plus hidden two-bit latch, no glitches.
// - Pin clears when buffered duty equals timer extended by two fine bits.
// - Buffered duty beyond the period never clears the pin that period.
// - Base timer prescale is 1, 4 or 16 input cycles per count.
// - Mode 0000 off and reset, 1011 trigger with flag, 11xx PWM.
`timescale 1ns/1ns
module cep_channel #(
   parameter bit ENHANCED = 1'b1
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Compare time bases and converter enable
   input  wire logic [15:0] first_timer_value,
   input  wire logic [15:0] third_timer_value,
   input  wire logic        third_timer_select,
   input  wire logic        first_timer_overflow,
   input  wire logic        adc_enabled,
   // Outputs
   output logic             first_timer_reset,
   output logic             third_timer_reset,
   output logic             adc_start,
   output logic             channel_pin
);

   // Registers
   logic [7:0]  duty_low_ff;
   logic [7:0]  duty_high_ff;
   logic [1:0]  duty_latch_ff;
   logic [7:0]  ctrl_ff;
   logic [7:0]  period_ff;
   logic [7:0]  tctrl_ff;
   logic [7:0]  flags_ff;
   logic [7:0]  enables_ff;
   logic [7:0]  priority_ff;
   logic        match_prev_ff;
   logic        ack_ff;
   logic [31:0] dat_ff;
   logic        pin_ff;
   logic        first_rst_ff;
   logic        third_rst_ff;
   logic        adc_ff;

   // Internal
   logic        req;
   logic        wr;
   logic [7:0]  wbyte;
   logic [7:0]  nxt_rdata;
   logic        pwm_mode;
   logic        trig_mode;
   logic        ctrl_zero_wr;
   logic        tick;
   logic [1:0]  fine;
   logic [7:0]  tmr_count;
   logic [7:0]  nxt_tmr_count;
   logic        period_end;
   logic        post_event;
   logic [9:0]  nxt_duty;
   logic        duty_match;
   logic [15:0] sel_timer;
   logic        cmp_match;
   logic        fire;

   assign req       = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr        = req && wb_we_i && wb_sel_i[0];
   assign wbyte     = wb_dat_i[7:0];
   assign pwm_mode  = cep_pkg::cep_is_pwm(ctrl_ff);
   assign trig_mode = ctrl_ff[cep_pkg::CTRL_MODE_LSB +: 4] == cep_pkg::MODE_TRIGGER;
   assign ctrl_zero_wr = wr && wb_adr_i == cep_pkg::OFS_CONTROL && wbyte == 8'h00;

   // Ten-bit duty assembled from low byte and control bits 5:4
   assign nxt_duty   = {duty_low_ff, ctrl_ff[cep_pkg::CTRL_DUTY_LSB +: 2]};
   // Position the timer reaches next cycle, so the registered pin falls on time
   assign nxt_tmr_count = period_end ? 8'h00 : (tick ? tmr_count + 8'h01 : tmr_count);
   // Buffered duty against the timer extended by fine bits; too large never matches
   assign duty_match = {duty_high_ff, duty_latch_ff} == {nxt_tmr_count, fine};

   assign sel_timer = third_timer_select ? third_timer_value : first_timer_value;
   assign cmp_match = {duty_high_ff, duty_low_ff} == sel_timer;
   // Fires once per match entry, so a held match does not retrigger
   assign fire      = trig_mode && cmp_match && !match_prev_ff;

   cep_prescaler u_prescaler (
      .clk     (clk),
      .reset   (reset),
      .run     (tctrl_ff[cep_pkg::TCTRL_ON_BIT]),
      .clear   (wr && wb_adr_i == cep_pkg::OFS_TIMER_CTRL),
      .pre_sel (tctrl_ff[cep_pkg::TCTRL_PRE_LSB +: 2]),
      .tick    (tick),
      .fine    (fine)
   );

   cep_base_timer #(
      .WIDTH (8)
   ) u_base_timer (
      .clk           (clk),
      .reset         (reset),
      .tick          (tick),
      .period        (period_ff),
      .post_sel      (tctrl_ff[cep_pkg::TCTRL_POST_LSB +: 4]),
      .count_ff      (tmr_count),
      .period_end    (period_end),
      .post_event_ff (post_event)
   );

   // Read data selection
   always_comb begin
      case (wb_adr_i)
         cep_pkg::OFS_DUTY_LOW:   nxt_rdata = duty_low_ff;
         cep_pkg::OFS_DUTY_HIGH:  nxt_rdata = duty_high_ff;
         cep_pkg::OFS_CONTROL:    nxt_rdata = ctrl_ff;
         cep_pkg::OFS_PERIOD:     nxt_rdata = period_ff;
         cep_pkg::OFS_TIMER_CTRL: nxt_rdata = tctrl_ff;
         cep_pkg::OFS_TIMER_CNT:  nxt_rdata = tmr_count;
         cep_pkg::OFS_FLAGS:      nxt_rdata = flags_ff;
         cep_pkg::OFS_ENABLES:    nxt_rdata = enables_ff;
         cep_pkg::OFS_PRIORITY:   nxt_rdata = priority_ff;
         default:                 nxt_rdata = 8'h00;
      endcase
   end

   // Bus answer: one wait state, ack for exactly one cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= req;
         if (req) begin
            dat_ff <= {24'h00_0000, nxt_rdata};
         end
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         duty_low_ff <= cep_pkg::DUTY_RST;
         period_ff   <= cep_pkg::PERIOD_RST;
         tctrl_ff    <= cep_pkg::TCTRL_RST;
         enables_ff  <= cep_pkg::ENABLES_RST;
         priority_ff <= cep_pkg::PRIORITY_RST;
      end else if (wr) begin
         case (wb_adr_i)
            cep_pkg::OFS_DUTY_LOW:   duty_low_ff <= wbyte;
            cep_pkg::OFS_PERIOD:     period_ff   <= wbyte;
            cep_pkg::OFS_TIMER_CTRL: tctrl_ff    <= wbyte & cep_pkg::TCTRL_IMPL_MASK;
            cep_pkg::OFS_ENABLES:    enables_ff  <= wbyte;
            cep_pkg::OFS_PRIORITY:   priority_ff <= wbyte;
            default: ;
         endcase
      end
   end

   // Channel control; upper two bits read as zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_ff <= cep_pkg::CTRL_RST;
      end else if (wr && wb_adr_i == cep_pkg::OFS_CONTROL) begin
         ctrl_ff <= wbyte & cep_pkg::CTRL_IMPL_MASK;
      end
   end

   // Duty buffer: loads only at the period end while in PWM
   // Software may write the high byte only outside PWM
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         duty_high_ff  <= cep_pkg::DUTY_RST;
         duty_latch_ff <= 2'h0;
      end else if (pwm_mode && period_end) begin
         duty_high_ff  <= nxt_duty[9:2];
         duty_latch_ff <= nxt_duty[1:0];
      end else if (!pwm_mode && wr && wb_adr_i == cep_pkg::OFS_DUTY_HIGH) begin
         duty_high_ff <= wbyte;
      end
   end

   // PWM output latch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_ff <= 1'b0;
      end else if (ctrl_zero_wr || !pwm_mode) begin
         // Only the PWM latch is cleared; no port data latch lives here
         pin_ff <= 1'b0;
      end else if (period_end) begin
         // Set at period start unless the new duty is zero
         pin_ff <= nxt_duty != 10'h000;
      end else if (duty_match) begin
         pin_ff <= 1'b0;
      end
   end

   // Special event trigger pulses toward timers and converter
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         match_prev_ff <= 1'b0;
         first_rst_ff  <= 1'b0;
         third_rst_ff  <= 1'b0;
         adc_ff        <= 1'b0;
      end else if (ctrl_zero_wr) begin
         match_prev_ff <= 1'b0;
         first_rst_ff  <= 1'b0;
         third_rst_ff  <= 1'b0;
         adc_ff        <= 1'b0;
      end else begin
         match_prev_ff <= trig_mode && cmp_match;
         first_rst_ff  <= fire && !third_timer_select;
         third_rst_ff  <= fire && third_timer_select;
         adc_ff        <= fire && adc_enabled && ENHANCED;
      end
   end

   // Flags: hardware set wins over a software write in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags_ff <= cep_pkg::FLAGS_RST;
      end else begin
         if (wr && wb_adr_i == cep_pkg::OFS_FLAGS) begin
            flags_ff <= wbyte;
         end
         if (fire) begin
            flags_ff[cep_pkg::FLAG_EVENT_BIT] <= 1'b1;
         end
         if (post_event) begin
            flags_ff[cep_pkg::FLAG_PWMT_BIT] <= 1'b1;
         end
         // An overflow coinciding with our own reset pulse is its echo, not a wrap
         if (first_timer_overflow && !first_rst_ff) begin
            flags_ff[cep_pkg::FLAG_FIRST_BIT] <= 1'b1;
         end
      end
   end

   assign wb_ack_o          = ack_ff;
   assign wb_dat_o          = dat_ff;
   assign channel_pin       = pin_ff;
   assign first_timer_reset = first_rst_ff;
   assign third_timer_reset = third_rst_ff;
   assign adc_start         = adc_ff;

   a_first_reset_sel: assert property (@(posedge clk) disable iff (reset)
      fire && !third_timer_select && !ctrl_zero_wr |=> first_timer_reset && !third_timer_reset)
      else $error("trigger did not reset the selected first timer");

   a_adc_start_gate: assert property (@(posedge clk) disable iff (reset)
      adc_start |-> $past(adc_enabled) && $past(fire))
      else $error("conversion started without an enabled converter");

   a_no_timer_flag: assert property (@(posedge clk) disable iff (reset)
      $rose(flags_ff[cep_pkg::FLAG_FIRST_BIT]) |->
         $past(first_timer_overflow && !first_rst_ff) || $past(wr && wb_adr_i == cep_pkg::OFS_FLAGS))
      else $error("first timer flag set by trigger reset");

   a_ctrl_zero_pin: assert property (@(posedge clk) disable iff (reset)
      ctrl_zero_wr |=> !channel_pin [*2])
      else $error("PWM latch not low after control cleared");

   a_period_set: assert property (@(posedge clk) disable iff (reset)
      pwm_mode && period_end && !wr |=> channel_pin == ($past(nxt_duty) != 10'h000))
      else $error("pin not set correctly at period start");

   a_duty_copy: assert property (@(posedge clk) disable iff (reset)
      pwm_mode && period_end |=> {duty_high_ff, duty_latch_ff} == $past(nxt_duty))
      else $error("duty not copied into buffer at period end");

   a_mid_hold: assert property (@(posedge clk) disable iff (reset)
      pwm_mode && !period_end |=> $stable(duty_latch_ff) && $stable(duty_high_ff))
      else $error("buffered duty changed inside a period");

   a_duty_clear: assert property (@(posedge clk) disable iff (reset)
      pwm_mode && !period_end && duty_match |=> !channel_pin)
      else $error("pin not cleared at duty match");

   a_trigger_flag: assert property (@(posedge clk) disable iff (reset)
      fire |=> flags_ff[cep_pkg::FLAG_EVENT_BIT] ##1 first_timer_reset || third_timer_reset ||
         flags_ff[cep_pkg::FLAG_EVENT_BIT] || $past(wr))
      else $error("trigger did not set the channel flag");

   a_third_reset_sel: assert property (@(posedge clk) disable iff (reset)
      fire && third_timer_select && !ctrl_zero_wr |=> third_timer_reset && !first_timer_reset)
      else $error("trigger did not reset the selected third timer");

   a_resets_exclusive: assert property (@(posedge clk) disable iff (reset)
      !(first_timer_reset && third_timer_reset))
      else $error("both timers reset by one trigger");

   a_reset_one_cycle: assert property (@(posedge clk) disable iff (reset)
      first_timer_reset || third_timer_reset |=> !first_timer_reset && !third_timer_reset)
      else $error("timer reset pulse longer than one cycle");

   a_adc_start_on: assert property (@(posedge clk) disable iff (reset)
      ENHANCED && fire && adc_enabled && !ctrl_zero_wr |=> adc_start)
      else $error("trigger did not start a conversion");

   a_echo_no_flag: assert property (@(posedge clk) disable iff (reset)
      first_timer_reset && first_timer_overflow && !flags_ff[cep_pkg::FLAG_FIRST_BIT] &&
         !(wr && wb_adr_i == cep_pkg::OFS_FLAGS) |=> !flags_ff[cep_pkg::FLAG_FIRST_BIT])
      else $error("trigger echo raised the first timer flag");

   a_count_step: assert property (@(posedge clk) disable iff (reset)
      tick && !period_end |=> tmr_count == $past(tmr_count) + 8'h01)
      else $error("base timer did not advance on its tick");

   a_pin_rise_start: assert property (@(posedge clk) disable iff (reset)
      $rose(channel_pin) |-> $past(pwm_mode && period_end))
      else $error("pin rose away from a period start");

   a_high_locked: assert property (@(posedge clk) disable iff (reset)
      pwm_mode && !period_end && wr && wb_adr_i == cep_pkg::OFS_DUTY_HIGH |=> $stable(duty_high_ff))
      else $error("high duty byte written in PWM mode");

   a_off_pin_low: assert property (@(posedge clk) disable iff (reset)
      !pwm_mode |=> !channel_pin)
      else $error("pin driven outside PWM mode");

   a_fire_once: assert property (@(posedge clk) disable iff (reset)
      fire |=> !fire)
      else $error("held compare match fired twice");

endmodule

// File: hdl/cep_pkg.sv
// Constants, register map and helpers shared by the event trigger and PWM channel
package cep_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] OFS_DUTY_LOW   = 8'h00;
   localparam logic [7:0] OFS_DUTY_HIGH  = 8'h04;
   localparam logic [7:0] OFS_CONTROL    = 8'h08;
   localparam logic [7:0] OFS_PERIOD     = 8'h0C;
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h10;
   localparam logic [7:0] OFS_TIMER_CNT  = 8'h14;
   localparam logic [7:0] OFS_FLAGS      = 8'h18;
   localparam logic [7:0] OFS_ENABLES    = 8'h1C;
   localparam logic [7:0] OFS_PRIORITY   = 8'h20;

   // Channel control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DUTY_LSB = 4;
   localparam logic [7:0] CTRL_IMPL_MASK = 8'h3F;

   // Timer control fields
   localparam int TCTRL_PRE_LSB  = 0;
   localparam int TCTRL_ON_BIT   = 2;
   localparam int TCTRL_POST_LSB = 3;
   localparam logic [7:0] TCTRL_IMPL_MASK = 8'h7F;

   // Flag bit positions
   localparam int FLAG_FIRST_BIT = 0;
   localparam int FLAG_PWMT_BIT  = 1;
   localparam int FLAG_EVENT_BIT = 2;

   // Values after reset
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] DUTY_RST     = 8'h00;
   localparam logic [7:0] PERIOD_RST   = 8'hFF;
   localparam logic [7:0] TCTRL_RST    = 8'h00;
   localparam logic [7:0] FLAGS_RST    = 8'h00;
   localparam logic [7:0] ENABLES_RST  = 8'h00;
   localparam logic [7:0] PRIORITY_RST = 8'hFF;

   // Mode codes
   localparam logic [3:0] MODE_OFF     = 4'h0;
   localparam logic [3:0] MODE_TRIGGER = 4'hB;
   localparam logic [1:0] MODE_PWM_HI  = 2'h3;

   // Oscillator cycles per timer input cycle
   localparam int unsigned OSC_PER_CYCLE = 4;

   typedef enum logic [1:0] {
      CEP_PRE_1,
      CEP_PRE_4,
      CEP_PRE_16A,
      CEP_PRE_16B
   } cep_pre_t;

   function automatic logic cep_is_pwm(input logic [7:0] ctrl);
      return ctrl[CTRL_MODE_LSB+3 -: 2] == MODE_PWM_HI;
   endfunction

   function automatic logic [5:0] cep_pre_limit(input logic [1:0] sel);
      case (cep_pre_t'(sel))
         CEP_PRE_1: return 6'(OSC_PER_CYCLE - 1);
         CEP_PRE_4: return 6'(OSC_PER_CYCLE * 4 - 1);
         default:   return 6'(OSC_PER_CYCLE * 16 - 1);
      endcase
   endfunction

endpackage

// File: hdl/cep_prescaler.sv
// Prescaler that paces the PWM base timer and supplies the two fine duty bits
`timescale 1ns/1ns
module cep_prescaler (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Control
   input  wire logic       run,
   input  wire logic       clear,
   input  wire logic [1:0] pre_sel,
   // Outputs
   output logic            tick,
   output logic [1:0]      fine
);

   logic [5:0] cnt_ff;
   logic [5:0] limit;
   logic [5:0] nxt_cnt;

   assign limit   = cep_pkg::cep_pre_limit(pre_sel);
   assign tick    = run && (cnt_ff >= limit);
   assign nxt_cnt = (clear || tick) ? 6'h00 : (run ? cnt_ff + 6'h01 : cnt_ff);

   // Fine bits of the coming cycle: the pin is registered, so the match leads by one
   always_comb begin
      case (cep_pkg::cep_pre_t'(pre_sel))
         cep_pkg::CEP_PRE_1: fine = nxt_cnt[1:0];
         cep_pkg::CEP_PRE_4: fine = nxt_cnt[3:2];
         default:            fine = nxt_cnt[5:4];
      endcase
   end

   // One tick every 4, 16 or 64 oscillator cycles
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_ff <= 6'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   a_tick_spacing: assert property (@(posedge clk) disable iff (reset)
      tick && !clear && pre_sel == 2'h0 |=> !tick [*3])
      else $error("prescaler ticked early at prescale one");

endmodule

// File: tb/cep_channel_tb.sv
// Self-checking bench for the event trigger and PWM channel
`timescale 1ns/1ns
module cep_channel_tb;
   logic        clk                  = 1'b0;
   logic        reset                = 1'b1;
   logic        wb_cyc_i             = 1'b0;
   logic        wb_stb_i             = 1'b0;
   logic        wb_we_i              = 1'b0;
   logic [7:0]  wb_adr_i             = 8'h00;
   logic [3:0]  wb_sel_i             = 4'h0;
   logic [31:0] wb_dat_i             = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [15:0] first_timer_value    = 16'h0;
   logic [15:0] third_timer_value    = 16'h0;
   logic        third_timer_select   = 1'b0;
   logic        first_timer_overflow = 1'b0;
   logic        adc_enabled          = 1'b0;
   logic        first_timer_reset;
   logic        third_timer_reset;
   logic        adc_start;
   logic        channel_pin;
   int          mismatches           = 0;
   int          checked              = 0;
   logic [7:0]  rd;

   always #5 clk = ~clk;

   cep_channel dut_u (
      .clk                  (clk),
      .reset                (reset),
      .wb_cyc_i             (wb_cyc_i),
      .wb_stb_i             (wb_stb_i),
      .wb_we_i              (wb_we_i),
      .wb_adr_i             (wb_adr_i),
      .wb_sel_i             (wb_sel_i),
      .wb_dat_i             (wb_dat_i),
      .wb_dat_o             (wb_dat_o),
      .wb_ack_o             (wb_ack_o),
      .first_timer_value    (first_timer_value),
      .third_timer_value    (third_timer_value),
      .third_timer_select   (third_timer_select),
      .first_timer_overflow (first_timer_overflow),
      .adc_enabled          (adc_enabled),
      .first_timer_reset    (first_timer_reset),
      .third_timer_reset    (third_timer_reset),
      .adc_start            (adc_start),
      .channel_pin          (channel_pin)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Classic single Wishbone cycle; waits for ack without assuming a latency
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h0, dat};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      check({31'h0, wb_ack_o}, 32'h1, "bus ack");
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      wb(1'b1, adr, dat);
   endtask

   task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
      wb(1'b0, adr, 8'h00);
      check({24'h0, rd}, {24'h0, exp}, "register read");
   endtask

   // One special event: selected timer matches 1234, expect one-cycle pulses
   task automatic trig(input logic sel3, input logic adc, input logic exp_adc);
      third_timer_select <= sel3;
      adc_enabled        <= adc;
      wr(cep_pkg::OFS_DUTY_LOW, 8'h34);
      wr(cep_pkg::OFS_DUTY_HIGH, 8'h12);
      wr(cep_pkg::OFS_CONTROL, 8'h0B);
      @(posedge clk);
      if (sel3) third_timer_value <= 16'h1234;
      else first_timer_value <= 16'h1234;
      @(posedge clk);
      first_timer_overflow <= ~sel3;
      #1;
      check(first_timer_reset, !sel3, "first timer reset");
      check(third_timer_reset, sel3, "third timer reset");
      check(adc_start, exp_adc, "conversion start");
      @(posedge clk);
      first_timer_overflow <= 1'b0;
      first_timer_value    <= 16'h0;
      third_timer_value    <= 16'h0;
      #1;
      check({first_timer_reset, third_timer_reset, adc_start}, 3'b000, "pulse length");
      rdc(cep_pkg::OFS_FLAGS, 8'h04);
      wr(cep_pkg::OFS_FLAGS, 8'h00);
      wr(cep_pkg::OFS_CONTROL, 8'h00);
   endtask

   // Waits for a low-to-high change of the pin, sampled mid-cycle
   // A lowered period can leave the count above it, so the first rise may wait a full wrap
   task automatic rise();
      int n;
      n = 0;
      @(negedge clk);
      while (channel_pin !== 1'b0 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      while (channel_pin !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      check({31'h0, channel_pin}, 32'h1, "pin rise");
   endtask

   // Setup in the prescribed order: period, duty, pin direction, timer, then mode
   // Pin direction belongs to the port outside this block; channel_pin is always driven
   task automatic setup(input logic [7:0] per, input logic [7:0] lo, input logic [1:0] lsb, input logic [7:0] tc);
      wr(cep_pkg::OFS_PERIOD, per);
      wr(cep_pkg::OFS_DUTY_LOW, lo);
      wr(cep_pkg::OFS_CONTROL, {2'b00, lsb, 4'h0});
      wr(cep_pkg::OFS_TIMER_CTRL, tc);
      wr(cep_pkg::OFS_CONTROL, {2'b00, lsb, 4'hC});
   endtask

   task automatic measure(input int hi, input int pd);
      int h;
      int t;
      h = 0;
      t = 0;
      rise();
      rise();
      while (channel_pin === 1'b1 && h < 3000) begin
         h++;
         @(negedge clk);
      end
      while (channel_pin !== 1'b1 && t < 3000) begin
         t++;
         @(negedge clk);
      end
      check(h, hi, "high time");
      check(h + t, pd, "period");
   endtask

   // Pin must hold one level for many periods
   task automatic flat(input logic exp);
      int bad;
      bad = 0;
      // First period start comes a few cycles after the mode write
      repeat (8) @(negedge clk);
      repeat (300) begin
         @(negedge clk);
         if (channel_pin !== exp) bad++;
      end
      check(bad, 0, "steady pin");
   endtask

   task automatic stop();
      wr(cep_pkg::OFS_CONTROL, 8'h00);
      repeat (2) @(negedge clk);
      check({31'h0, channel_pin}, 32'h0, "pin after off");
   endtask

   logic [7:0] ofs [10];
   logic [7:0] rv  [10];

   initial begin
      ofs = '{cep_pkg::OFS_DUTY_LOW, cep_pkg::OFS_DUTY_HIGH, cep_pkg::OFS_CONTROL, cep_pkg::OFS_PERIOD,
              cep_pkg::OFS_TIMER_CTRL, cep_pkg::OFS_TIMER_CNT, cep_pkg::OFS_FLAGS, cep_pkg::OFS_ENABLES,
              cep_pkg::OFS_PRIORITY, 8'h24};
      rv  = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      foreach (ofs[i]) rdc(ofs[i], rv[i]);
      wr(cep_pkg::OFS_ENABLES, 8'hA5);
      rdc(cep_pkg::OFS_ENABLES, 8'hA5);
      wr(cep_pkg::OFS_CONTROL, 8'hFA);
      rdc(cep_pkg::OFS_CONTROL, 8'h3A);
      wr(cep_pkg::OFS_CONTROL, 8'h00);
      wr(cep_pkg::OFS_TIMER_CNT, 8'h55);
      rdc(cep_pkg::OFS_TIMER_CNT, 8'h00);
      // Trigger on each time base with converter on, then on the first time base with it off
      trig(1'b0, 1'b1, 1'b1);
      trig(1'b1, 1'b1, 1'b1);
      trig(1'b0, 1'b0, 1'b0);
      // A plain overflow with no trigger pulse beside it must still raise its flag
      first_timer_overflow <= 1'b1;
      @(posedge clk);
      first_timer_overflow <= 1'b0;
      rdc(cep_pkg::OFS_FLAGS, 8'h01);
      wr(cep_pkg::OFS_FLAGS, 8'h00);
      // Prescale 1: duty 5, period 4 counts
      setup(8'h03, 8'h01, 2'b01, 8'h04);
      measure(5, 16);
      wr(cep_pkg::OFS_DUTY_HIGH, 8'h77);
      rdc(cep_pkg::OFS_DUTY_HIGH, 8'h01);
      wr(cep_pkg::OFS_DUTY_LOW, 8'h02);
      rise();
      rise();
      rdc(cep_pkg::OFS_DUTY_HIGH, 8'h02);
      stop();
      // Prescale 4 with a postscaler that must not stretch the period, then prescale 16 twice without one
      setup(8'h01, 8'h01, 2'b10, 8'h1D);
      measure(24, 32);
      stop();
      setup(8'h00, 8'h00, 2'b11, 8'h06);
      measure(48, 64);
      stop();
      setup(8'h00, 8'h00, 2'b01, 8'h07);
      measure(16, 64);
      stop();
      // Zero duty stays low; duty past the period stays high
      setup(8'h00, 8'h00, 2'b00, 8'h04);
      flat(1'b0);
      stop();
      setup(8'h00, 8'h01, 2'b00, 8'h04);
      flat(1'b1);
      stop();
      summarize();
   end

   initial begin
      #500000;
      mismatches++;
      summarize();
   end
endmodule
